// ===== hdl/hbd_host_ctrl.sv
// Host-side controller that drives an H-bridge through its three logic
// inputs and watches its open-collector thermal warning line.
// Assumes an APB master on clk_sys and a pull-up on the warning line.
`timescale 1ns/1ns

module hbd_host_ctrl (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [hbd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    output logic                            irq,
    output logic                            dir_pin,
    output logic                            brake_pin,
    output logic                            pwm_pin,
    input  wire logic                       thermal_n_pin
);
    import hbd_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_ff;
    logic [PWM_W-1:0]  period_ff;
    logic [PWM_W-1:0]  duty_ff;
    logic [INT_W-1:0]  int_stat_ff;
    logic [INT_W-1:0]  int_mask_ff;
    logic [31:0]       prdata_ff;
    logic              stop_ff;

    // ----------------------------------------------------------------
    // Pin state
    // ----------------------------------------------------------------
    logic              dir_ff;
    logic              brake_ff;
    logic              pwm_ff;
    hbd_sp_t           sp_ff;
    logic [GAP_W-1:0]  gap_ff;

    // ----------------------------------------------------------------
    // Warning line synchroniser
    // ----------------------------------------------------------------
    logic              warn_s1_ff;
    logic              warn_s2_ff;
    logic              warn_s3_ff;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire acc      = psel && penable && ce;
    wire setup    = psel && !penable && ce;
    wire rd_setup = setup && !pwrite;

    // Byte offsets, one whole word each
    wire sel_ctrl = (paddr == REG_CTRL);
    wire sel_per  = (paddr == REG_PERIOD);
    wire sel_duty = (paddr == REG_DUTY);
    wire sel_stat = (paddr == REG_STATUS);
    wire sel_ist  = (paddr == REG_INT_STAT);
    wire sel_imsk = (paddr == REG_INT_MASK);
    wire hit      = sel_ctrl || sel_per || sel_duty || sel_stat || sel_ist || sel_imsk;

    wire wr       = acc && pwrite && hit;
    wire wr_ctrl  = wr && sel_ctrl;
    wire wr_per   = wr && sel_per;
    wire wr_duty  = wr && sel_duty;
    wire wr_ist   = wr && sel_ist;
    wire wr_imsk  = wr && sel_imsk;

    // ----------------------------------------------------------------
    // Warning events
    // ----------------------------------------------------------------
    wire warn_on  = warn_s3_ff && !warn_s2_ff;
    wire warn_off = !warn_s3_ff && warn_s2_ff;
    wire warn_lvl = !warn_s2_ff;

    wire [INT_W-1:0] ev;
    assign ev[INT_WARN_ON]  = warn_on;
    assign ev[INT_WARN_OFF] = warn_off;

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    // Set wins over a same-cycle write-one-to-clear
    wire [INT_W-1:0] ist_clr      = wr_ist ? pwdata[INT_W-1:0] : INT_RST;
    wire [INT_W-1:0] nxt_int_stat = (int_stat_ff & ~ist_clr) | ev;

    // ----------------------------------------------------------------
    // Auto stop
    // ----------------------------------------------------------------
    // Auto stop holds until software clears the warning-on status bit
    wire stop_set = warn_on && ctrl_ff[CTRL_AUTOSTOP];
    wire stop_clr = ist_clr[INT_WARN_ON];
    wire nxt_stop = stop_set || (stop_ff && !stop_clr);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [31:0] stat_word;
    assign stat_word[STAT_DIR]   = dir_ff;
    assign stat_word[STAT_PWM]   = pwm_ff;
    assign stat_word[STAT_BRAKE] = brake_ff;
    assign stat_word[STAT_WARN]  = warn_lvl;
    assign stat_word[STAT_STOP]  = stop_ff;
    assign stat_word[STAT_BUSY]  = (sp_ff == HBD_SP_HOLD);
    assign stat_word[31:6]       = 26'h0;

    wire [31:0] rd_word =
        sel_ctrl ? {27'h0, ctrl_ff} :
        sel_per  ? {16'h0000, period_ff} :
        sel_duty ? {16'h0000, duty_ff} :
        sel_stat ? stat_word :
        sel_ist  ? {30'h0, int_stat_ff} :
        sel_imsk ? {30'h0, int_mask_ff} : 32'h00000000;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_ff   <= CTRL_RST;
            period_ff <= PERIOD_RST;
            duty_ff   <= DUTY_RST;
        end else if (ce) begin
            if (wr_ctrl) ctrl_ff <= pwdata[CTRL_W-1:0];
            if (wr_per) period_ff <= pwdata[PWM_W-1:0];
            if (wr_duty) duty_ff <= pwdata[PWM_W-1:0];
        end
    end

    // Events land in every enabled cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            int_stat_ff <= INT_RST;
            int_mask_ff <= INT_RST;
            stop_ff     <= 1'b0;
        end else if (ce) begin
            int_stat_ff <= nxt_int_stat;
            stop_ff     <= nxt_stop;
            if (wr_imsk) int_mask_ff <= pwdata[INT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Read data capture
    // ----------------------------------------------------------------
    // Taken in setup so the access phase needs no wait state
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prdata_ff <= 32'h00000000;
        end else if (ce && rd_setup) begin
            prdata_ff <= rd_word;
        end
    end

    // ----------------------------------------------------------------
    // Synchroniser flops
    // ----------------------------------------------------------------
    // Reset to high: an idle open-collector line reads as no warning
    // Third flop only feeds the edge detector
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            warn_s1_ff <= 1'b1;
            warn_s2_ff <= 1'b1;
            warn_s3_ff <= 1'b1;
        end else if (ce) begin
            warn_s1_ff <= thermal_n_pin;
            warn_s2_ff <= warn_s1_ff;
            warn_s3_ff <= warn_s2_ff;
        end
    end

    // ----------------------------------------------------------------
    // Pulse source
    // ----------------------------------------------------------------
    logic pulse;

    // Held at zero while the drive is disabled
    hbd_pwm_gen u_pwm (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .run     (ctrl_ff[CTRL_EN]),
        .period  (period_ff),
        .duty    (duty_ff),
        .pulse   (pulse)
    );

    // ----------------------------------------------------------------
    // Wanted pin levels
    // ----------------------------------------------------------------
    wire halt    = !ctrl_ff[CTRL_EN] || stop_ff;
    wire brk     = ctrl_ff[CTRL_BRAKE];
    wire sgn_mag = ctrl_ff[CTRL_MODE];
    wire sgn     = ctrl_ff[CTRL_SIGN];

    // Halt asks for brake high with magnitude low, all switches off
    wire want_brake = halt || brk;
    wire want_pwm   = halt    ? 1'b0 :
                      brk     ? 1'b1 :
                      sgn_mag ? pulse :
                      1'b1;
    wire want_dir   = halt    ? 1'b0 :
                      brk     ? sgn :
                      sgn_mag ? sgn :
                      pulse;

    // ----------------------------------------------------------------
    // Pending moves
    // ----------------------------------------------------------------
    // Any difference waits for the scheduler
    wire d_brake = want_brake != brake_ff;
    wire d_pwm   = want_pwm != pwm_ff;
    wire d_dir   = want_dir != dir_ff;
    wire d_any   = d_brake || d_pwm || d_dir;

    // ----------------------------------------------------------------
    // Pin change scheduler
    // ----------------------------------------------------------------
    // One pin per move, then a full gap; short pulses are stretched,
    // so duty resolution is limited to the gap near 0 and full scale
    wire go = (sp_ff == HBD_SP_IDLE) && d_any;

    hbd_sp_t nxt_sp;
    always_comb begin
        nxt_sp = sp_ff;
        unique case (sp_ff)
            HBD_SP_IDLE: if (go) nxt_sp = HBD_SP_HOLD;
            HBD_SP_HOLD: if (gap_ff == 9'h000) nxt_sp = HBD_SP_IDLE;
            default:     nxt_sp = HBD_SP_IDLE;
        endcase
    end

    wire [GAP_W-1:0] nxt_gap = go ? EDGE_GAP_CYC - 9'h002 :
                               (gap_ff == 9'h000) ? 9'h000 : gap_ff - 9'h001;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sp_ff  <= HBD_SP_IDLE;
            gap_ff <= 9'h000;
        end else if (ce) begin
            sp_ff  <= nxt_sp;
            gap_ff <= nxt_gap;
        end
    end

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    // Reset leaves every switch off: brake high, magnitude low
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            brake_ff <= 1'b1;
            pwm_ff   <= 1'b0;
            dir_ff   <= 1'b0;
        end else if (ce && go) begin
            if (d_brake) brake_ff <= want_brake;
            else if (d_pwm) pwm_ff <= want_pwm;
            else dir_ff <= want_dir;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready    = ce;
    // Unmapped reads also return zero
    assign pslverr   = acc && !hit;
    assign prdata    = prdata_ff;

    // ----------------------------------------------------------------
    // Interrupt and pin outputs
    // ----------------------------------------------------------------
    assign irq       = |(int_stat_ff & int_mask_ff);

    assign dir_pin   = dir_ff;
    assign brake_pin = brake_ff;
    assign pwm_pin   = pwm_ff;

endmodule

// ===== hdl/hbd_pkg.sv
// Constants shared by the H-bridge host controller and its pulse generator.
// Assumes a 250 MHz system clock and a 32-bit APB register port.
package hbd_pkg;

    // ----------------------------------------------------------------
    // Clock and pin timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned EDGE_GAP_NS   = 1000;
    localparam int unsigned EDGE_QUIET_NS = 500;
    localparam int unsigned GAP_NS_MAX    = (EDGE_GAP_NS > EDGE_QUIET_NS) ?
                                            EDGE_GAP_NS : EDGE_QUIET_NS;
    localparam int unsigned GAP_W         = 9;
    // Least time, so round up to whole cycles
    localparam logic [GAP_W-1:0] EDGE_GAP_CYC =
        GAP_W'((GAP_NS_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DUTY     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h14;

    localparam int unsigned CTRL_W        = 5;
    localparam int unsigned CTRL_EN       = 0;
    localparam int unsigned CTRL_MODE     = 1;
    localparam int unsigned CTRL_SIGN     = 2;
    localparam int unsigned CTRL_BRAKE    = 3;
    localparam int unsigned CTRL_AUTOSTOP = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    localparam int unsigned PWM_W = 16;
    localparam logic [PWM_W-1:0] PERIOD_RST = 16'h0FA0;
    localparam logic [PWM_W-1:0] DUTY_RST   = 16'h07D0;

    localparam int unsigned STAT_DIR   = 0;
    localparam int unsigned STAT_PWM   = 1;
    localparam int unsigned STAT_BRAKE = 2;
    localparam int unsigned STAT_WARN  = 3;
    localparam int unsigned STAT_STOP  = 4;
    localparam int unsigned STAT_BUSY  = 5;

    localparam int unsigned INT_W        = 2;
    localparam int unsigned INT_WARN_ON  = 0;
    localparam int unsigned INT_WARN_OFF = 1;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;

    // ----------------------------------------------------------------
    // Pin change scheduler states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HBD_SP_IDLE = 2'b00,
        HBD_SP_HOLD = 2'b01
    } hbd_sp_t;

endpackage

// ===== hdl/hbd_pwm_gen.sv
// Free running pulse-width generator for the H-bridge host controller.
// Assumes period and duty come from registers on the same clock.
`timescale 1ns/1ns
module hbd_pwm_gen (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    input  wire logic                      run,
    input  wire logic [hbd_pkg::PWM_W-1:0] period,
    input  wire logic [hbd_pkg::PWM_W-1:0] duty,
    output logic                           pulse
);
    import hbd_pkg::*;

    logic [PWM_W-1:0] cnt_ff;
    logic [PWM_W-1:0] per_sh_ff;
    logic [PWM_W-1:0] duty_sh_ff;
    logic             pulse_ff;

    // ----------------------------------------------------------------
    // Period counter
    // ----------------------------------------------------------------
    // Shadow copies load only at wrap so a write never tears a period
    wire              wrap     = (cnt_ff >= per_sh_ff - 16'h0001) || !run;
    wire [PWM_W-1:0]  nxt_cnt  = wrap ? 16'h0000 : cnt_ff + 16'h0001;
    wire              nxt_high = run && (nxt_cnt < (wrap ? duty : duty_sh_ff));

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_ff     <= 16'h0000;
            per_sh_ff  <= PERIOD_RST;
            duty_sh_ff <= DUTY_RST;
            pulse_ff   <= 1'b0;
        end else if (ce) begin
            cnt_ff   <= nxt_cnt;
            pulse_ff <= nxt_high;
            if (wrap) begin
                per_sh_ff  <= period;
                duty_sh_ff <= duty;
            end
        end
    end

    assign pulse = pulse_ff;

endmodule

// ===== testbench/hbd_bridge_model.sv
// Behavioural model of the H-bridge that the controller drives.
// Assumes a pull-up on the warning line outside this model.
`timescale 1ns/1ns
module hbd_bridge_model (
    input  wire logic       dir_in,
    input  wire logic       brake_in,
    input  wire logic       pwm_in,
    input  wire logic [7:0] temp_c,
    input  wire logic       over_amp,
    output logic            src1,
    output logic            snk1,
    output logic            src2,
    output logic            snk2,
    output logic            sense_on,
    output logic            flag_oe
);
    logic off;
    // ----------------------------------------------------------------
    // Decode and protection
    // ----------------------------------------------------------------
    // Cut-off follows the fault, so its clearing stands for the retry
    assign off  = (temp_c >= 8'hAA) || over_amp;
    assign src1 = !off && ((!pwm_in && !brake_in) || (pwm_in && dir_in));
    assign snk1 = !off && pwm_in && !dir_in;
    assign src2 = !off && ((!pwm_in && !brake_in)
                  || (pwm_in && (brake_in ? dir_in : !dir_in)));
    assign snk2 = !off && pwm_in && (brake_in ? !dir_in : dir_in);
    // Freewheel through both sources or both sinks is not sensed
    assign sense_on = (src1 && snk2) || (src2 && snk1);
    // Open collector: pulls low only, switches keep running
    assign flag_oe = temp_c >= 8'h91;
endmodule

// ===== testbench/hbd_host_checker.sv
// Concurrent checks on the pins and interrupt of the H-bridge host controller.
// Assumes it is bound to hbd_host_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module hbd_host_checker (
    input wire logic                       clk_sys,
    input wire logic                       nrst,
    input wire logic                       ce,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [hbd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic                       pready,
    input wire logic [31:0]                prdata,
    input wire logic                       pslverr,
    input wire logic                       irq,
    input wire logic                       dir_pin,
    input wire logic                       brake_pin,
    input wire logic                       pwm_pin,
    input wire logic                       thermal_n_pin
);
    import hbd_pkg::*;
    logic [2:0]        pins;
    logic [2:0]        prev_ff;
    logic [GAP_W-1:0]  gap_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [INT_W-1:0]  mask_ff;
    logic              wr;
    logic              chg;
    logic              anti;
    logic              sgm;
    // ----------------------------------------------------------------
    // Shadow of the control and mask registers, pin edge spacing
    // ----------------------------------------------------------------
    assign pins = {dir_pin, brake_pin, pwm_pin};
    assign wr   = psel & penable & pwrite & ce;
    assign chg  = pins != prev_ff;
    // Autostop excluded: a latched stop is not visible at the ports
    assign anti = ctrl_ff[CTRL_EN] & !ctrl_ff[CTRL_MODE] & !ctrl_ff[CTRL_BRAKE]
                  & !ctrl_ff[CTRL_AUTOSTOP];
    assign sgm  = ctrl_ff[CTRL_EN] & ctrl_ff[CTRL_MODE] & !ctrl_ff[CTRL_BRAKE]
                  & !ctrl_ff[CTRL_AUTOSTOP];
    always_ff @(posedge clk_sys) begin
        prev_ff <= pins;
        if (!nrst) begin
            gap_ff  <= '1;
            ctrl_ff <= CTRL_RST;
            mask_ff <= INT_RST;
        end else begin
            gap_ff <= chg ? '0 : ((gap_ff == '1) ? gap_ff : gap_ff + 1'b1);
            if (wr && paddr == REG_CTRL) ctrl_ff <= pwdata[CTRL_W-1:0];
            if (wr && paddr == REG_INT_MASK) mask_ff <= pwdata[INT_W-1:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_gap;
        chg |-> gap_ff >= EDGE_GAP_CYC - 1'b1;
    endproperty
    a_gap: assert property (p_gap) else $error("pin edges too close");
    property p_single;
        $countones(pins ^ prev_ff) <= 1;
    endproperty
    a_single: assert property (p_single) else $error("coincident pin edges");
    property p_anti;
        anti && $stable(ctrl_ff) && $past(ctrl_ff, 2) == ctrl_ff |-> !$fell(pwm_pin);
    endproperty
    a_anti: assert property (p_anti) else $error("magnitude fell in anti-phase");
    property p_sgm;
        $changed(dir_pin) && sgm && $stable(ctrl_ff) && $past(ctrl_ff, 2) == ctrl_ff
            |-> dir_pin == ctrl_ff[CTRL_SIGN];
    endproperty
    a_sgm: assert property (p_sgm) else $error("sense differs from sign");
    property p_halt;
        chg && !ctrl_ff[CTRL_EN] && $stable(ctrl_ff) && $past(ctrl_ff, 2) == ctrl_ff
            |-> $rose(brake_pin) || $fell(pwm_pin) || $fell(dir_pin);
    endproperty
    a_halt: assert property (p_halt) else $error("pin moved away from off");
    property p_irq_on;
        $fell(thermal_n_pin) && mask_ff[INT_WARN_ON] |-> ##[1:6] irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("no interrupt on warning");
    property p_irq_off;
        mask_ff == INT_RST && $past(mask_ff) == INT_RST |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while masked");
    property p_stop;
        $fell(thermal_n_pin) && ctrl_ff[CTRL_AUTOSTOP] && ctrl_ff[CTRL_EN] && !brake_pin
            |-> ##[1:300] brake_pin;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop on warning");
    c_irq: cover property ($rose(irq));
    c_dir: cover property (anti && $changed(dir_pin));
    c_pwm: cover property (sgm && $changed(pwm_pin));
endmodule

bind hbd_host_ctrl hbd_host_checker u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .dir_pin(dir_pin),
    .brake_pin(brake_pin), .pwm_pin(pwm_pin), .thermal_n_pin(thermal_n_pin)
);

// ===== testbench/testbench.sv
// Self-checking bench for the H-bridge host controller and a bridge model.
// Assumes the checker binds itself; the warning line has a pull-up here.
`timescale 1ns/1ns
module testbench;
    import hbd_pkg::*;
    logic              clk_sys, nrst, ce, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, seed;
    logic              dir_pin, brake_pin, pwm_pin, thermal_n_pin, er, over_amp;
    logic              src1, snk1, src2, snk2, flag_oe, sense_on;
    logic [7:0]        temp_c;
    logic [15:0]       per, dut_y;
    int                fail_count, n_checks, tg_dir, tg_pwm;
    logic [7:0]        ra[6] = '{REG_CTRL, REG_PERIOD, REG_DUTY, REG_STATUS, REG_INT_STAT,
                                 REG_INT_MASK};
    logic [31:0]       rv[6] = '{32'h0, 32'h0FA0, 32'h07D0, 32'h4, 32'h0, 32'h0};
    logic [4:0]        cv[6] = '{5'h01, 5'h07, 5'h03, 5'h0D, 5'h09, 5'h00};
    assign thermal_n_pin = flag_oe ? 1'b0 : 1'b1;
    hbd_host_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq), .dir_pin(dir_pin),
        .brake_pin(brake_pin), .pwm_pin(pwm_pin), .thermal_n_pin(thermal_n_pin));
    hbd_bridge_model u_brg (.dir_in(dir_pin), .brake_in(brake_pin), .pwm_in(pwm_pin),
        .temp_c(temp_c), .over_amp(over_amp), .src1(src1), .snk1(snk1), .src2(src2),
        .snk2(snk2), .sense_on(sense_on), .flag_oe(flag_oe));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Mask and level of {dir, brake, magnitude} once the pins settle
    function automatic logic [5:0] exp_pins(input logic [4:0] c);
        if (!c[CTRL_EN]) return 6'b111_010;
        if (c[CTRL_BRAKE]) return {3'b111, c[CTRL_SIGN], 2'b11};
        if (c[CTRL_MODE]) return {3'b110, c[CTRL_SIGN], 2'b00};
        return 6'b011_001;
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(nm, exp, rd & m);
    endtask
    // Fixed spans of 1000 cycles and more are whole multiples of the pin spacing
    task automatic run(input int n);
        logic [2:0] p;
        p = {dir_pin, brake_pin, pwm_pin};
        tg_dir = 0;
        tg_pwm = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (dir_pin !== p[2]) tg_dir++;
            if (pwm_pin !== p[0]) tg_pwm++;
            p = {dir_pin, brake_pin, pwm_pin};
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, over_amp} = '0;
        ce = 1'b1;
        temp_c = 8'h19;
        seed = 32'hCB559975;
        fail_count = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        cmp("pins at reset", 3'b010, {dir_pin, brake_pin, pwm_pin});
        for (int i = 0; i < 6; i++) rdc("reset value", ra[i], 32'hFFFFFFFF, rv[i]);
        apb(1'b0, 8'h18, 32'h0);
        cmp("unmapped error", 1'b1, er);
        cmp("unmapped data", 32'h0, rd);
        seed = lfsr(seed);
        per = 16'h0400 + {6'h0, seed[9:0]};
        seed = lfsr(seed);
        dut_y = per / 4 + 16'(seed % (per / 2));
        apb(1'b1, REG_PERIOD, {16'h0, per});
        apb(1'b1, REG_DUTY, {16'h0, dut_y});
        rdc("period", REG_PERIOD, 32'hFFFF, {16'h0, per});
        rdc("duty", REG_DUTY, 32'hFFFF, {16'h0, dut_y});
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, REG_CTRL, {27'h0, cv[i]});
            run(4000);
            cmp("pins", exp_pins(cv[i]) & 6'h7, {dir_pin, brake_pin, pwm_pin}
                & exp_pins(cv[i]) >> 3);
            if (cv[i] == 5'h01) cmp("sense toggles", 1, tg_dir > 0);
            if (cv[i][CTRL_MODE] && !cv[i][CTRL_BRAKE]) begin
                cmp("pulse", 1, tg_pwm > 0);
                cmp("drive sensed", pwm_pin, sense_on);
            end
            if (cv[i] == 5'h0D) begin
                cmp("short", 4'hA, {src1, snk1, src2, snk2});
                cmp("short unsensed", 0, sense_on);
                over_amp <= 1'b1;
                run(1);
                cmp("overcurrent", 0, {src1, snk1, src2, snk2});
                over_amp <= 1'b0;
            end
        end
        cmp("switches off", 4'h0, {src1, snk1, src2, snk2});
        apb(1'b1, REG_INT_MASK, 32'h3);
        apb(1'b1, REG_CTRL, 32'h11);
        run(1000);
        ce <= 1'b0;
        run(1);
        run(300);
        cmp("frozen pins", 0, tg_dir + tg_pwm);
        cmp("frozen bus", 1'b0, pready);
        ce <= 1'b1;
        temp_c <= 8'h96;
        run(8);
        cmp("irq on", 1'b1, irq);
        rdc("warn event", REG_INT_STAT, 32'h1, 32'h1);
        rdc("warn status", REG_STATUS, 32'h18, 32'h18);
        run(1500);
        cmp("stopped", 3'b010, {dir_pin, brake_pin, pwm_pin});
        temp_c <= 8'h19;
        run(8);
        rdc("release event", REG_INT_STAT, 32'h2, 32'h2);
        apb(1'b1, REG_INT_STAT, 32'h3);
        rdc("cleared", REG_INT_STAT, 32'h3, 32'h0);
        cmp("irq off", 1'b0, irq);
        run(1500);
        cmp("resumed", 1'b0, brake_pin);
        apb(1'b1, REG_INT_MASK, 32'h0);
        temp_c <= 8'h96;
        run(8);
        cmp("irq masked", 1'b0, irq);
        rdc("masked event", REG_INT_STAT, 32'h1, 32'h1);
        test_done();
    end
endmodule
